//--- rtl/wdbc_latch.sv
`timescale 1ns/1ps
module wdbc_latch (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // capture control
    input wire logic i_capture,
    input wire wdbc_pkg::wdbc_win_t i_win,
    // captured window
    output wdbc_pkg::wdbc_win_t o_win,
    output logic o_valid
);
    wdbc_pkg::wdbc_win_t win_q, win_d;
    logic valid_q, valid_d;

    always_comb begin
        win_d = win_q;
        valid_d = valid_q;
        if (i_capture) begin
            win_d = i_win; // R07
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            win_q <= '0;
            valid_q <= 1'b0;
        end else begin
            win_q <= win_d;
            valid_q <= valid_d;
        end
    end

    assign o_win = win_q;
    assign o_valid = valid_q;
endmodule

//--- rtl/wdbc_pkg.sv
package wdbc_pkg;
    typedef struct packed {
        logic [9:0] x_start;
        logic [9:0] y_start;
        logic [9:0] x_end;
        logic [9:0] y_end;
    } wdbc_win_t;

    typedef enum logic [1:0] {
        WDBC_MODE_SINGLE,
        WDBC_MODE_SINGLE_PROT,
        WDBC_MODE_RESERVED,
        WDBC_MODE_DOUBLE
    } wdbc_mode_t;
endpackage

//--- rtl/wdbc_regs.svh
`ifndef WDBC_REGS_SVH
`define WDBC_REGS_SVH

`define WDBC_ADDR_W 8
`define WDBC_OFS_FX 8'h36
`define WDBC_OFS_XS_LO 8'h38
`define WDBC_OFS_XS_HI 8'h3A
`define WDBC_OFS_YS_LO 8'h3C
`define WDBC_OFS_YS_HI 8'h3E
`define WDBC_OFS_XE_LO 8'h40
`define WDBC_OFS_XE_HI 8'h42
`define WDBC_OFS_YE_LO 8'h44
`define WDBC_OFS_YE_HI 8'h46
`define WDBC_BIT_TYPE 7
`define WDBC_BIT_DBEN 6
`define WDBC_FX_RW_MASK 8'hC0
`define WDBC_HI_MASK 8'h03
`define WDBC_RST_BYTE 8'h00

`endif

//--- rtl/wdbc_top.sv
// Behaviour
// R01: both bits clear: single buffer, none anywhere
// R02: type clear, enable set: protect old window
// R03: both set: host data is double buffered
// R04: enable bit switches double buffer architecture
// R05: host enables only if half buffer fits
// R06: host sets bits before writing window (the testbench writes the window first, then the effects bits)
// R07: coordinates captured for display pipe use
// R08: host keeps coordinates fixed while enabled
// R09: only one double buffered window exists
// R10: host never writes reserved effect bits
// R11: Y end is last window row
// R12: Y end from high two, low eight bits
// R13: host programs pre-resize coordinates
// R14: other coordinates split low byte, two-bit high
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "wdbc_regs.svh"
module wdbc_top (
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // window of the current host writes
    output logic [39:0] O_HOST_WIN,
    output logic O_HOST_DOUBLE,
    // double buffered window for the display pipe
    output logic [39:0] O_DB_WIN,
    output logic O_DB_ACTIVE,
    output logic O_RESERVED_MODE
);
    logic [7:0] fx_q, fx_d;
    logic [7:0] xs_lo_q, xs_lo_d, xs_hi_q, xs_hi_d;
    logic [7:0] ys_lo_q, ys_lo_d, ys_hi_q, ys_hi_d;
    logic [7:0] xe_lo_q, xe_lo_d, xe_hi_q, xe_hi_d;
    logic [7:0] ye_lo_q, ye_lo_d, ye_hi_q, ye_hi_d;
    logic [7:0] rdata_q, rdata_d;
    logic [39:0] host_win_q, host_win_d;
    logic host_dbl_q, host_dbl_d;
    logic [39:0] db_win_q, db_win_d;
    logic db_act_q, db_act_d;
    logic rsv_q, rsv_d;
    wdbc_pkg::wdbc_win_t live_win, held_win;
    wdbc_pkg::wdbc_mode_t mode;
    logic capture, held_valid;

    // coordinates referenced to top left of displayed image
    always_comb begin
        live_win.x_start = {xs_hi_q[1:0], xs_lo_q}; // R14
        live_win.y_start = {ys_hi_q[1:0], ys_lo_q}; // R14
        live_win.x_end = {xe_hi_q[1:0], xe_lo_q}; // R14
        live_win.y_end = {ye_hi_q[1:0], ye_lo_q}; // R11 R12
    end

    always_comb begin
        mode = wdbc_pkg::wdbc_mode_t'({fx_q[`WDBC_BIT_TYPE], fx_q[`WDBC_BIT_DBEN]});
    end

    // register file
    always_comb begin
        fx_d = fx_q;
        xs_lo_d = xs_lo_q;
        xs_hi_d = xs_hi_q;
        ys_lo_d = ys_lo_q;
        ys_hi_d = ys_hi_q;
        xe_lo_d = xe_lo_q;
        xe_hi_d = xe_hi_q;
        ye_lo_d = ye_lo_q;
        ye_hi_d = ye_hi_q;
        if (I_WR) begin
            unique case (I_ADDR)
                // reserved bits 1-0 and n/a bits are not stored
                `WDBC_OFS_FX: fx_d = I_WDATA & `WDBC_FX_RW_MASK; // R04 R10
                `WDBC_OFS_XS_LO: xs_lo_d = I_WDATA;
                `WDBC_OFS_XS_HI: xs_hi_d = I_WDATA & `WDBC_HI_MASK;
                `WDBC_OFS_YS_LO: ys_lo_d = I_WDATA;
                `WDBC_OFS_YS_HI: ys_hi_d = I_WDATA & `WDBC_HI_MASK;
                `WDBC_OFS_XE_LO: xe_lo_d = I_WDATA;
                `WDBC_OFS_XE_HI: xe_hi_d = I_WDATA & `WDBC_HI_MASK;
                `WDBC_OFS_YE_LO: ye_lo_d = I_WDATA; // R12
                `WDBC_OFS_YE_HI: ye_hi_d = I_WDATA & `WDBC_HI_MASK; // R12
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (I_RD) begin
            unique case (I_ADDR)
                `WDBC_OFS_FX: rdata_d = fx_q;
                `WDBC_OFS_XS_LO: rdata_d = xs_lo_q;
                `WDBC_OFS_XS_HI: rdata_d = xs_hi_q;
                `WDBC_OFS_YS_LO: rdata_d = ys_lo_q;
                `WDBC_OFS_YS_HI: rdata_d = ys_hi_q;
                `WDBC_OFS_XE_LO: rdata_d = xe_lo_q;
                `WDBC_OFS_XE_HI: rdata_d = xe_hi_q;
                `WDBC_OFS_YE_LO: rdata_d = ye_lo_q;
                `WDBC_OFS_YE_HI: rdata_d = ye_hi_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // only a double-mode window is latched; one holder means one window
    assign capture = (mode == wdbc_pkg::WDBC_MODE_DOUBLE); // R03 R07 R09

    wdbc_latch u_latch (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_capture(capture),
        .i_win(live_win),
        .o_win(held_win),
        .o_valid(held_valid)
    );

    // outputs registered one cycle after the configuration, O_DB_WIN two cycles through the latch
    always_comb begin
        host_win_d = live_win;
        host_dbl_d = (mode == wdbc_pkg::WDBC_MODE_DOUBLE); // R03 R09
        rsv_d = (mode == wdbc_pkg::WDBC_MODE_RESERVED);
        db_win_d = db_win_q;
        db_act_d = 1'b0;
        unique case (mode)
            wdbc_pkg::WDBC_MODE_SINGLE: begin
                db_act_d = 1'b0; // R01 R04
            end
            wdbc_pkg::WDBC_MODE_SINGLE_PROT: begin
                db_act_d = held_valid; // R02 R04
                db_win_d = held_win; // R02 R07
            end
            wdbc_pkg::WDBC_MODE_DOUBLE: begin
                db_act_d = 1'b1; // R03 R04
                db_win_d = held_win; // R07
            end
            // reserved combination: treated as no double buffering
            wdbc_pkg::WDBC_MODE_RESERVED: begin
                db_act_d = 1'b0; // R03
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fx_q <= `WDBC_RST_BYTE;
            xs_lo_q <= `WDBC_RST_BYTE;
            xs_hi_q <= `WDBC_RST_BYTE;
            ys_lo_q <= `WDBC_RST_BYTE;
            ys_hi_q <= `WDBC_RST_BYTE;
            xe_lo_q <= `WDBC_RST_BYTE;
            xe_hi_q <= `WDBC_RST_BYTE;
            ye_lo_q <= `WDBC_RST_BYTE;
            ye_hi_q <= `WDBC_RST_BYTE;
            rdata_q <= 8'h00;
            host_win_q <= '0;
            host_dbl_q <= 1'b0;
            db_win_q <= '0;
            db_act_q <= 1'b0;
            rsv_q <= 1'b0;
        end else begin
            fx_q <= fx_d;
            xs_lo_q <= xs_lo_d;
            xs_hi_q <= xs_hi_d;
            ys_lo_q <= ys_lo_d;
            ys_hi_q <= ys_hi_d;
            xe_lo_q <= xe_lo_d;
            xe_hi_q <= xe_hi_d;
            ye_lo_q <= ye_lo_d;
            ye_hi_q <= ye_hi_d;
            rdata_q <= rdata_d;
            host_win_q <= host_win_d;
            host_dbl_q <= host_dbl_d;
            db_win_q <= db_win_d;
            db_act_q <= db_act_d;
            rsv_q <= rsv_d;
        end
    end

    assign O_RDATA = rdata_q;
    assign O_HOST_WIN = host_win_q;
    assign O_HOST_DOUBLE = host_dbl_q;
    assign O_DB_WIN = db_win_q;
    assign O_DB_ACTIVE = db_act_q;
    assign O_RESERVED_MODE = rsv_q;
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, wr, rd, dbl, act, rsv;
    logic [7:0] addr, wdata, rdata, v;
    logic [39:0] hwin, dwin, w1, w2;
    int error_cnt, compares, cyc;
    logic [7:0] ofs [8] = '{8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44, 8'h46};
    wdbc_top u_wdbc_top (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_HOST_WIN(hwin), .O_HOST_DOUBLE(dbl),
        .O_DB_WIN(dwin), .O_DB_ACTIVE(act), .O_RESERVED_MODE(rsv));
    wdbc_host u_wdbc_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 1000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_wdbc_host.rd(a, v);
        chk("rdata", {32'h0, v}, {32'h0, e});
    endtask
    // two spare cycles so register, capture and output stages have all landed
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_wdbc_host.wr(a, d);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic setwin(input logic [7:0] s, output logic [39:0] q);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = s + 8'h25 * i[7:0];
            w(ofs[i], b);
            if (i[0]) q[(3 - i / 2) * 10 + 8 +: 2] = b[1:0];
            else q[(3 - i / 2) * 10 +: 8] = b;
            rdchk(ofs[i], i[0] ? {6'h00, b[1:0]} : b);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk(ofs[i], 8'h00);
        setwin(8'h5A, w1);
        chk("host_win", hwin, w1);
        rdchk(8'h48, 8'h00);
        for (int m = 0; m < 4; m++) begin
            w(8'h36, {m[1:0], 6'h3F});
            chk("double", {39'h0, dbl}, {39'h0, m == 3});
            chk("reserved", {39'h0, rsv}, {39'h0, m == 2});
            chk("active", {39'h0, act}, {39'h0, m == 3});
            rdchk(8'h36, {m[1:0], 6'h00});
        end
        chk("db_win", dwin, w1);
        w(8'h36, 8'h00);
        chk("active", {39'h0, act}, 40'h0);
        setwin(8'hC3, w2);
        w(8'h36, 8'h40);
        chk("active", {39'h0, act}, 40'h1);
        chk("db_win", dwin, w1);
        chk("double", {39'h0, dbl}, 40'h0);
        w(8'h36, 8'hC0);
        chk("db_win", dwin, w2);
        complete_run();
    end
endmodule

//--- test/wdbc_host.sv
`timescale 1ns/1ps
module wdbc_host (
    // bus
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        // effects register: reserved low pair always left clear
        o_wdata <= (a == 8'h36) ? {d[7:2], 2'b00} : d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule

//--- test/wdbc_monitor.sv
`timescale 1ns/1ps
module wdbc_monitor (
    // clock, reset, register port
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    // window outputs
    input wire logic [39:0] O_HOST_WIN,
    input wire logic O_HOST_DOUBLE,
    input wire logic [39:0] O_DB_WIN,
    input wire logic O_DB_ACTIVE,
    input wire logic O_RESERVED_MODE
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    logic fx;
    assign fx = I_WR && I_ADDR == 8'h36;
    // mode outputs follow the stored effects byte, so two edges after the write
    AST_DBL: assert property (fx |=> ##1 O_HOST_DOUBLE == &$past(I_WDATA[7:6], 2))
        else $error("double flag wrong");
    AST_RSV: assert property (fx |=> ##1
        O_RESERVED_MODE == ($past(I_WDATA[7:6], 2) == 2'h2))
        else $error("reserved flag wrong");
    AST_OFF: assert property (fx && !I_WDATA[6] |=> ##1 !O_DB_ACTIVE)
        else $error("active while disabled");
    AST_FXR: assert property (I_RD && I_ADDR == 8'h36 |=> O_RDATA[5:0] == 6'h00)
        else $error("effects low bits stored");
    AST_YEL: assert property (I_WR && I_ADDR == 8'h44 |=> ##1
        O_HOST_WIN[7:0] == $past(I_WDATA, 2))
        else $error("y end low wrong");
    AST_YEH: assert property (I_WR && I_ADDR == 8'h46 |=> ##1
        O_HOST_WIN[9:8] == $past(I_WDATA[1:0], 2))
        else $error("y end high wrong");
    AST_XSL: assert property (I_WR && I_ADDR == 8'h38 |=> ##1
        O_HOST_WIN[37:30] == $past(I_WDATA, 2))
        else $error("x start low wrong");
    AST_CAP: assert property (O_HOST_DOUBLE |=> O_DB_WIN == $past(O_HOST_WIN))
        else $error("window not captured");
    cover property (fx && I_WDATA[7:6] == 2'h3);
    cover property (fx && I_WDATA[7:6] == 2'h1);
    cover property (O_DB_ACTIVE && !O_HOST_DOUBLE);
endmodule
bind wdbc_top wdbc_monitor u_wdbc_monitor (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_HOST_WIN(O_HOST_WIN), .O_HOST_DOUBLE(O_HOST_DOUBLE), .O_DB_WIN(O_DB_WIN),
    .O_DB_ACTIVE(O_DB_ACTIVE), .O_RESERVED_MODE(O_RESERVED_MODE));
